// [hdl/pcr_pkg.sv]
// Constants for the port pin configuration register block.
// Assumes an 8-bit special_function_register bus with page select.
// Function
// - A 1 in a port2_crossbar_bypass bit makes the crossbar skip that pin.
// - Writing port3_pin_data loads each pin's output latch, 0 low, 1 high.
// - Reading port3_pin_data returns the sensed pin level, not the latch.
// - port3_pin_data is at 0xB0 on every page and is bit-addressable.
// - Bypass, input and output mode registers decode only on page 0x0F.
// - An input mode bit of 0 makes the pin analog, 1 keeps it digital.
// - An analog pin has its weak pull-up and digital receiver turned off.
// - The output mode bit is ignored for a pin in analog mode.
// - For a digital pin, output mode 0 is open-drain and 1 is push-pull.
// - Mode register bit n belongs to pin n, for bits 7 down to 0.
// - A Port 2 pin with input mode bit 0 is analog, pull-up and receiver off.
package pcr_pkg;
    localparam logic [7:0] PCR_ADDR_OUT_MODE  = 8'h00ae;
    localparam logic [7:0] PCR_ADDR_PIN_DATA  = 8'h00b0;
    localparam logic [7:0] PCR_ADDR_BYPASS    = 8'h00d6;
    localparam logic [7:0] PCR_ADDR_ANA_SEL   = 8'h00f4;
    localparam logic [7:0] PCR_CONFIG_PAGE    = 8'h000f;
    localparam logic [7:0] PCR_RST_OUT_MODE   = 8'h0000;
    localparam logic [7:0] PCR_RST_PIN_DATA   = 8'h00ff;
    localparam logic [7:0] PCR_RST_BYPASS     = 8'h0000;
    localparam logic [7:0] PCR_RST_ANA_SEL    = 8'h00ff;
    localparam logic [7:0] PCR_RST_P2_ANA_SEL = 8'h00ff;
endpackage

// [hdl/pcr_port_regs.sv]
// Port 2 bypass and Port 3 data and mode registers behind the sfr bus.
// Assumes single-cycle sfr strobes on clock; pins come in unsynchronised.
`timescale 1ns/1ps
`default_nettype none
module pcr_port_regs
    import pcr_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [7:0]       sfr_addr,
    input  wire logic [7:0]       sfr_page,
    input  wire logic             sfr_wr,
    input  wire logic             sfr_rd,
    input  wire logic [7:0]       sfr_wdata,
    input  wire logic             sfr_bit_op,
    input  wire logic [2:0]       sfr_bit_sel,
    input  wire logic             sfr_bit_val,
    output logic      [7:0]       sfr_rdata,
    output logic                  sfr_hit,
    input  wire logic [WIDTH-1:0] p3_pin_in,
    output logic      [WIDTH-1:0] p3_pin_out,
    output logic      [WIDTH-1:0] p3_pin_oe,
    output logic      [WIDTH-1:0] p3_pullup_en,
    output logic      [WIDTH-1:0] p3_receiver_en,
    input  wire logic [WIDTH-1:0] port2_analog_digital_select,
    output logic      [WIDTH-1:0] p2_pullup_en,
    output logic      [WIDTH-1:0] p2_receiver_en,
    output logic      [WIDTH-1:0] port2_crossbar_bypass
);
    logic             rst_meta;
    logic             rst_sync_n;
    logic [WIDTH-1:0] port3_pin_data;
    logic [WIDTH-1:0] port3_analog_digital_select;
    logic [WIDTH-1:0] port3_output_drive_mode;
    logic [WIDTH-1:0] pin_s1;
    logic [WIDTH-1:0] pin_s2;
    logic [WIDTH-1:0] pin_s3;
    logic [WIDTH-1:0] pin_level;
    logic [WIDTH-1:0] next_pin_level;
    logic             sel_data;
    logic             sel_bypass;
    logic             sel_ana;
    logic             sel_out;

    // Config registers only exist on their own page
    function automatic logic cfg_hit(input logic [7:0] a, input logic [7:0] p,
                                     input logic [7:0] target);
        cfg_hit = (a == target) && (p == PCR_CONFIG_PAGE);
    endfunction

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    assign sel_data   = (sfr_addr == PCR_ADDR_PIN_DATA);
    assign sel_bypass = cfg_hit(sfr_addr, sfr_page, PCR_ADDR_BYPASS);
    assign sel_ana    = cfg_hit(sfr_addr, sfr_page, PCR_ADDR_ANA_SEL);
    assign sel_out    = cfg_hit(sfr_addr, sfr_page, PCR_ADDR_OUT_MODE);

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            port3_pin_data <= WIDTH'(PCR_RST_PIN_DATA);
        end else if (sfr_wr && sel_data) begin
            if (sfr_bit_op) begin
                port3_pin_data[sfr_bit_sel] <= sfr_bit_val;
            end else begin
                port3_pin_data <= sfr_wdata[WIDTH-1:0];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            port2_crossbar_bypass       <= WIDTH'(PCR_RST_BYPASS);
            port3_analog_digital_select <= WIDTH'(PCR_RST_ANA_SEL);
            port3_output_drive_mode     <= WIDTH'(PCR_RST_OUT_MODE);
        end else if (sfr_wr) begin
            if (sel_bypass) begin
                port2_crossbar_bypass <= sfr_wdata[WIDTH-1:0];
            end else if (sel_ana) begin
                port3_analog_digital_select <= sfr_wdata[WIDTH-1:0];
            end else if (sel_out) begin
                port3_output_drive_mode <= sfr_wdata[WIDTH-1:0];
            end
        end
    end

    // Three-stage pin synchroniser; level follows when stages 2 and 3 agree
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_s1    <= '0;
            pin_s2    <= '0;
            pin_s3    <= '0;
            pin_level <= '0;
        end else begin
            pin_s1    <= p3_pin_in;
            pin_s2    <= pin_s1;
            pin_s3    <= pin_s2;
            pin_level <= next_pin_level;
        end
    end

    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_pin
            assign next_pin_level[i] = !port3_analog_digital_select[i] ? 1'b0
                : (pin_s2[i] == pin_s3[i]) ? pin_s3[i] : pin_level[i];
        end
    endgenerate

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sfr_rdata <= 8'h0000;
            sfr_hit   <= 1'b0;
        end else begin
            sfr_hit <= (sfr_rd || sfr_wr)
                && (sel_data || sel_bypass || sel_ana || sel_out);
            if (!sfr_rd) begin
                sfr_rdata <= 8'h0000;
            end else if (sel_data) begin
                sfr_rdata <= 8'(pin_level);
            end else if (sel_bypass) begin
                sfr_rdata <= 8'(port2_crossbar_bypass);
            end else if (sel_ana) begin
                sfr_rdata <= 8'(port3_analog_digital_select);
            end else if (sel_out) begin
                sfr_rdata <= 8'(port3_output_drive_mode);
            end else begin
                sfr_rdata <= 8'h0000;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            p3_pin_out     <= '0;
            p3_pin_oe      <= '0;
            p3_pullup_en   <= '0;
            p3_receiver_en <= '0;
            p2_pullup_en   <= '0;
            p2_receiver_en <= '0;
        end else begin
            // Open-drain only pulls low; push-pull drives both levels
            p3_pin_out     <= port3_pin_data;
            p3_pin_oe      <= port3_analog_digital_select
                & (port3_output_drive_mode | ~port3_pin_data);
            p3_pullup_en   <= port3_analog_digital_select & port3_pin_data;
            p3_receiver_en <= port3_analog_digital_select;
            p2_pullup_en   <= port2_analog_digital_select;
            p2_receiver_en <= port2_analog_digital_select;
        end
    end
endmodule
`default_nettype wire

// [testbench/pcr_regs_monitor.sv]
// Concurrent checks on the port configuration register block.
// Bound to pcr_port_regs; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pcr_regs_monitor
    import pcr_pkg::*;
#(parameter int WIDTH = 8) (
    input wire logic             clock,
    input wire logic             rst_n,
    input wire logic [7:0]       sfr_addr,
    input wire logic [7:0]       sfr_page,
    input wire logic             sfr_wr,
    input wire logic             sfr_rd,
    input wire logic [7:0]       sfr_wdata,
    input wire logic             sfr_bit_op,
    input wire logic [7:0]       sfr_rdata,
    input wire logic             sfr_hit,
    input wire logic [WIDTH-1:0] p3_pin_out,
    input wire logic [WIDTH-1:0] p3_pin_oe,
    input wire logic [WIDTH-1:0] p3_pullup_en,
    input wire logic [WIDTH-1:0] p3_receiver_en,
    input wire logic [WIDTH-1:0] port2_crossbar_bypass
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    chk_oe_analog_off: assert property (
        (p3_pin_oe & ~p3_receiver_en) == '0) else $error("analog pin driven");
    chk_pullup_digital: assert property (
        p3_pullup_en == (p3_receiver_en & p3_pin_out)) else $error("pull-up");
    chk_low_driven: assert property (
        (p3_receiver_en & ~p3_pin_out & ~p3_pin_oe) == '0) else $error("low");
    chk_rdata_idle: assert property (
        !sfr_rd |=> sfr_rdata == 8'h00) else $error("rdata not idle");
    chk_wrong_page: assert property (
        (sfr_wr || sfr_rd) && sfr_addr == PCR_ADDR_BYPASS && sfr_page != 8'h0f
        |=> !sfr_hit && sfr_rdata == 8'h00) else $error("wrong page hit");
    chk_data_any_page: assert property (
        (sfr_wr || sfr_rd) && sfr_addr == PCR_ADDR_PIN_DATA |=> sfr_hit)
        else $error("data register missed");
    chk_bypass_write: assert property (
        sfr_wr && sfr_addr == PCR_ADDR_BYPASS && sfr_page == 8'h0f
        |=> port2_crossbar_bypass == $past(sfr_wdata)) else $error("bypass");
    chk_latch_write: assert property (
        sfr_wr && !sfr_bit_op && sfr_addr == PCR_ADDR_PIN_DATA
        |=> ##1 p3_pin_out == $past(sfr_wdata, 2)) else $error("latch");
endmodule
`default_nettype wire

// [testbench/port_pin_config_regs_bench.sv]
// Self-checking bench for the port configuration registers.
// Drives sfr bus and pins on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module port_pin_config_regs_bench;
    import pcr_pkg::*;
    logic       clock, rst_n, sfr_wr, sfr_rd, sfr_bit_op, sfr_bit_val, sfr_hit;
    logic [2:0] sfr_bit_sel;
    logic [7:0] sfr_addr, sfr_page, sfr_wdata, sfr_rdata, p3_pin_in;
    logic [7:0] p3_pin_out, p3_pin_oe, p3_pullup_en, p3_receiver_en;
    logic [7:0] port2_analog_digital_select, p2_pullup_en, p2_receiver_en;
    logic [7:0] port2_crossbar_bypass;
    int         err_total, comparisons;
    pcr_port_regs #(.WIDTH(8)) dut (.*);
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Ends one negedge after pin outputs follow the register
    task automatic wr(input logic [7:0] a, input logic [7:0] p, d);
        @(negedge clock);
        {sfr_addr, sfr_page, sfr_wdata, sfr_wr} = {a, p, d, 1'b1};
        @(negedge clock);
        {sfr_wr, sfr_bit_op} = 2'b00;
        @(negedge clock);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] p, e);
        @(negedge clock);
        {sfr_addr, sfr_page, sfr_rd} = {a, p, 1'b1};
        @(negedge clock);
        sfr_rd = 1'b0;
        chk(sfr_rdata, e);
    endtask
    task automatic t_reset;
        rdchk(8'hae, 8'h0f, 8'h00);
        rdchk(8'hd6, 8'h0f, 8'h00);
        rdchk(8'hf4, 8'h0f, 8'hff);
        chk({p3_pin_out ^ 8'hff} | p3_pin_oe, 8'h00);
    endtask
    task automatic t_bypass;
        wr(8'hd6, 8'h0f, 8'ha5);
        chk(port2_crossbar_bypass, 8'ha5);
        wr(8'hd6, 8'h00, 8'h5a);
        rdchk(8'hd6, 8'h00, 8'h00);
        rdchk(8'hd6, 8'h0f, 8'ha5);
    endtask
    task automatic t_data;
        wr(8'hb0, 8'h00, 8'h3c);
        chk(p3_pin_out, 8'h3c);
        {sfr_bit_op, sfr_bit_sel, sfr_bit_val} = {1'b1, 3'd0, 1'b1};
        wr(8'hb0, 8'h0f, 8'h00);
        chk(p3_pin_out, 8'h3d);
        p3_pin_in = 8'h5a;
        repeat (6) @(negedge clock);
        rdchk(8'hb0, 8'h00, 8'h5a);
    endtask
    task automatic t_modes;
        wr(8'hf4, 8'h0f, 8'hf0);
        wr(8'hae, 8'h0f, 8'hff);
        chk(p3_receiver_en, 8'hf0);
        chk(p3_pin_oe, 8'hf0);
        chk(p3_pullup_en, 8'h30);
        wr(8'hae, 8'h0f, 8'h00);
        chk(p3_pin_oe, 8'hc0);
        port2_analog_digital_select = 8'h0f;
        repeat (6) @(negedge clock);
        chk(p2_pullup_en & p2_receiver_en, 8'h0f);
        rdchk(8'hb0, 8'h00, 8'h50);
    endtask
    task automatic results;
        if (err_total == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        {rst_n, sfr_wr, sfr_rd, sfr_bit_op, sfr_bit_val, sfr_bit_sel} = '0;
        {sfr_addr, sfr_page, sfr_wdata} = '0;
        {p3_pin_in, port2_analog_digital_select} = 16'hffff;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        repeat (3) @(negedge clock);
        t_reset;
        t_bypass;
        t_data;
        t_modes;
        results;
    end
    // About 50 cycles of traffic; 800 cycles means a hang
    initial begin
        #20000;
        err_total++;
        results;
    end
endmodule
bind pcr_port_regs pcr_regs_monitor #(.WIDTH(WIDTH)) u_mon (.*);
`default_nettype wire
